// ===== verilog/sfc_cfg.svh
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
// opcodes
`define SFC_OP_WREN   8'h06
`define SFC_OP_WRDI   8'h04
`define SFC_OP_RDSR1  8'h05
`define SFC_OP_PP     8'h02
`define SFC_OP_BE4    8'h20
`define SFC_OP_BE32   8'h52
`define SFC_OP_BE64   8'hd8
`define SFC_OP_CE_A   8'h60
`define SFC_OP_CE_B   8'hc7
`define SFC_OP_SUSP   8'h75
// status_reg_one fields
`define SFC_SR1_BUSY     0
`define SFC_SR1_WEL      1
`define SFC_SR1_BP_LSB   2
`define SFC_SR_RST       8'h00
// array geometry in bytes
`define SFC_MEM_BYTES    524288
`define SFC_PAGE_BYTES   256
`define SFC_BLK4_BYTES   4096
`define SFC_BLK32_BYTES  32768
`define SFC_BLK64_BYTES  65536
`define SFC_ERASED       8'hff
// frame lengths in bytes
`define SFC_ADDR_END     4
`define SFC_PP_MIN       5
// host timing in ref clocks
`define SFC_SCK_DIV      4
`define SFC_CS_HIGH_CYC  8
`endif

// ===== verilog/sfc_pkg.sv
package sfc_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_erase = 2'b01,
    st_prog  = 2'b10
  } sfc_dev_st_t;
  typedef enum logic [1:0] {
    hs_idle = 2'b00,
    hs_run  = 2'b01,
    hs_tail = 2'b10,
    hs_gap  = 2'b11
  } sfc_host_st_t;
endpackage

// ===== verilog/sfc_spi_if.sv
interface sfc_spi_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  // undriven data-out line reads low
  assign so_line = so_oe ? so : 1'b0;
  modport dev  (input sck, input cs_n, input si, output so, output so_oe);
  modport host (output sck, output cs_n, output si, input so_line);
endinterface

// ===== verilog/sfc_flash_dev.sv
`include "sfc_cfg.svh"
// How it works
// - busy bit 0 high during erase
// - erase clears write enable latch early
// - unaligned chip select rise aborts operation
// - abort clears write enable latch
// - block erase needs all three address bytes
// - protected block erase returns idle
// - erase failure sets erase and program errors
// - 60h and C7h both chip erase
// - host sends write enable first
// - any protection blocks chip erase
// - chip erase opcode only, starts on deselect
// - suspend ignored during chip erase
// - host sends 02h, address, data MSB first
// - one to 256 bytes, rest stay erased
// - deselect after data starts page program
// - page data wraps inside page
// - only last 256 bytes are kept
// - protected page program returns idle
// - short address or partial byte aborts
// - host polls busy bit
// - block size by opcode, low bits ignored
// - block erase starts on deselect
module sfc_flash_dev #(
  parameter int MEM_BYTES = `SFC_MEM_BYTES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  sfc_spi_if.dev           spi,
  input  wire logic [2:0]  block_protect_field_i,
  input  wire logic        lock_scheme_select_i,
  input  wire logic        block_lock_any_i,
  input  wire logic        erase_fault_i,
  input  wire logic [23:0] rd_addr_i,
  output logic             busy_o,
  output logic             wel_o,
  output logic             erase_error_flag_o,
  output logic             program_error_flag_o,
  output logic [7:0]       rd_data_o
);
  localparam int AW = $clog2(MEM_BYTES);
  if (MEM_BYTES < `SFC_BLK64_BYTES || (1 << AW) != MEM_BYTES || AW > 24) begin : g_chk
    $error("MEM_BYTES must be a power of two from 64 kB to 16 MB");
  end
  // link side, clocked by sck
  logic         act_r, frame_tgl_r, so_r, so_oe_r, byte_done, pp_wr;
  logic [2:0]   bit_cnt_r, bit_base;
  logic [11:0]  byte_cnt_r, byte_base;
  logic [7:0]   shift_r, opcode_r, dcnt_r, in_byte, dptr, sr1_sck;
  logic [23:0]  addr_r;
  logic [255:0] valid_r;
  logic [7:0]   buf_r [256];
  logic [4:0]   sr_s1_r, sr_s2_r;
  assign bit_base  = act_r ? bit_cnt_r : 3'd0;
  assign byte_base = act_r ? byte_cnt_r : 12'd0;
  assign in_byte   = {shift_r[6:0], spi.si};
  assign byte_done = (bit_base == 3'd7);
  // data lands at start offset plus count, mod page: wrap and keep-last fall out
  assign dptr      = 8'(addr_r[7:0] + dcnt_r);
  // no buffer writes while the array copy may be reading it
  assign pp_wr     = byte_done && (byte_base >= 12'(`SFC_ADDR_END)) &&
                     (opcode_r == `SFC_OP_PP) && !sr_s2_r[`SFC_SR1_BUSY];
  assign sr1_sck   = {3'b000, sr_s2_r};
  always_ff @(posedge spi.sck or posedge spi.cs_n or negedge nrst_i) begin
    if (!nrst_i || spi.cs_n) begin
      act_r <= 1'b0;
    end else begin
      act_r <= 1'b1;
    end
  end
  always_ff @(posedge spi.sck or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r   <= 3'd0;
      byte_cnt_r  <= 12'd0;
      shift_r     <= 8'h00;
      opcode_r    <= 8'h00;
      addr_r      <= 24'h000000;
      dcnt_r      <= 8'h00;
      frame_tgl_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_base + 3'd1;
      shift_r   <= in_byte;
      if (!act_r) begin
        frame_tgl_r <= ~frame_tgl_r;
      end
      if (byte_done && byte_base != 12'hfff) begin
        byte_cnt_r <= byte_base + 12'd1;
      end else begin
        byte_cnt_r <= byte_base;
      end
      if (byte_base < 12'(`SFC_ADDR_END)) begin
        dcnt_r <= 8'h00;
      end else if (byte_done) begin
        dcnt_r <= dcnt_r + 8'd1;
      end
      if (byte_done) begin
        if (byte_base == 12'd0) begin
          opcode_r <= in_byte;
        end else if (byte_base < 12'(`SFC_ADDR_END)) begin
          addr_r <= {addr_r[15:0], in_byte};
        end
      end
    end
  end
  always_ff @(posedge spi.sck or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_r <= '0;
    end else if (byte_done && byte_base == 12'd0 && !sr_s2_r[`SFC_SR1_BUSY]) begin
      // a status poll during the copy must not wipe the map
      valid_r <= '0;
    end else if (pp_wr) begin
      valid_r[dptr] <= 1'b1;
    end
  end
  always_ff @(posedge spi.sck) begin
    if (pp_wr) begin
      buf_r[dptr] <= in_byte;
    end
  end
  // status bits are near static; a two-edge lag is acceptable for polling
  always_ff @(posedge spi.sck or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_s1_r <= 5'd0;
      sr_s2_r <= 5'd0;
    end else begin
      sr_s1_r <= {block_protect_field_i, wel_o, busy_o};
      sr_s2_r <= sr_s1_r;
    end
  end
  always_ff @(negedge spi.sck or posedge spi.cs_n or negedge nrst_i) begin
    if (!nrst_i || spi.cs_n) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= (opcode_r == `SFC_OP_RDSR1) && (byte_cnt_r != 12'd0);
      so_r    <= sr1_sck[~bit_cnt_r];
    end
  end
  assign spi.so    = so_r;
  assign spi.so_oe = so_oe_r;
  // core side, clocked by ref_clk
  logic                 cs_s1_r, cs_s2_r, cs_d3_r, tgl_s1_r, tgl_s2_r, tgl_seen_r;
  logic                 frame_end, aligned, is_be, is_ce, is_pp, gated, len_ok, prot, go;
  sfc_pkg::sfc_dev_st_t state_r;
  logic [AW-1:0]        ptr_r, left_r, erase_len;
  logic [7:0]           mem [MEM_BYTES];
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_s1_r    <= 1'b1;
      cs_s2_r    <= 1'b1;
      cs_d3_r    <= 1'b1;
      tgl_s1_r   <= 1'b0;
      tgl_s2_r   <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      cs_s1_r  <= spi.cs_n;
      cs_s2_r  <= cs_s1_r;
      cs_d3_r  <= cs_s2_r;
      tgl_s1_r <= frame_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      if (cs_s2_r && !cs_d3_r) begin
        tgl_seen_r <= tgl_s2_r;
      end
    end
  end
  // frame fields are stable once sck has stopped and chip select is high
  // while busy every frame is dropped, suspend included
  assign frame_end = cs_s2_r && !cs_d3_r && (tgl_s2_r != tgl_seen_r) &&
                     (state_r == sfc_pkg::st_idle);
  assign aligned   = (bit_cnt_r == 3'd0);
  assign is_be     = (opcode_r == `SFC_OP_BE4) || (opcode_r == `SFC_OP_BE32) ||
                     (opcode_r == `SFC_OP_BE64);
  assign is_ce     = (opcode_r == `SFC_OP_CE_A) || (opcode_r == `SFC_OP_CE_B);
  assign is_pp     = (opcode_r == `SFC_OP_PP);
  assign gated     = frame_end && (is_be || is_ce || is_pp) && wel_o;
  assign len_ok    = is_ce ? 1'b1 :
                     is_be ? (byte_cnt_r >= 12'(`SFC_ADDR_END)) :
                             (byte_cnt_r >= 12'(`SFC_PP_MIN));
  // protection is whole-array: any set field or enabled lock blocks all
  assign prot      = (block_protect_field_i != 3'd0) ||
                     (lock_scheme_select_i && block_lock_any_i);
  assign go        = gated && aligned && len_ok && !prot;
  always_comb begin
    case (opcode_r)
      `SFC_OP_BE4:  erase_len = AW'(`SFC_BLK4_BYTES - 1);
      `SFC_OP_BE32: erase_len = AW'(`SFC_BLK32_BYTES - 1);
      `SFC_OP_BE64: erase_len = AW'(`SFC_BLK64_BYTES - 1);
      default:      erase_len = AW'(MEM_BYTES - 1);
    endcase
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= sfc_pkg::st_idle;
      busy_o  <= 1'b0;
      ptr_r   <= '0;
      left_r  <= '0;
    end else begin
      case (state_r)
        sfc_pkg::st_idle: begin
          if (go && is_pp) begin
            state_r <= sfc_pkg::st_prog;
            busy_o  <= 1'b1;
            ptr_r   <= {addr_r[AW-1:8], 8'h00};
            left_r  <= AW'(`SFC_PAGE_BYTES - 1);
          end else if (go) begin
            state_r <= sfc_pkg::st_erase;
            busy_o  <= 1'b1;
            ptr_r   <= addr_r[AW-1:0] & ~erase_len;
            left_r  <= erase_len;
          end
        end
        sfc_pkg::st_erase, sfc_pkg::st_prog: begin
          ptr_r  <= ptr_r + AW'(1);
          left_r <= left_r - AW'(1);
          if (left_r == '0) begin
            state_r <= sfc_pkg::st_idle;
            busy_o  <= 1'b0;
          end
        end
        default: begin
          state_r <= sfc_pkg::st_idle;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end
  // every gated outcome drops the latch: success, abort or protection
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wel_o <= 1'(`SFC_SR_RST >> `SFC_SR1_WEL);
    end else if (gated) begin
      wel_o <= 1'b0;
    end else if (frame_end && aligned && opcode_r == `SFC_OP_WREN) begin
      wel_o <= 1'b1;
    end else if (frame_end && aligned && opcode_r == `SFC_OP_WRDI) begin
      wel_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      erase_error_flag_o   <= 1'b0;
      program_error_flag_o <= 1'b0;
    end else if (state_r == sfc_pkg::st_erase && erase_fault_i) begin
      erase_error_flag_o   <= 1'b1;
      program_error_flag_o <= 1'b1;
    end else if (go) begin
      erase_error_flag_o   <= 1'b0;
      program_error_flag_o <= 1'b0;
    end
  end
  // program only clears bits, so untouched or unsent bytes keep their value
  always_ff @(posedge ref_clk_i) begin
    if (state_r == sfc_pkg::st_erase) begin
      mem[ptr_r] <= `SFC_ERASED;
    end else if (state_r == sfc_pkg::st_prog && valid_r[ptr_r[7:0]]) begin
      mem[ptr_r] <= mem[ptr_r] & buf_r[ptr_r[7:0]];
    end
  end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem[rd_addr_i[AW-1:0]];
    end
  end
endmodule

// ===== verilog/sfc_flash_host.sv
`include "sfc_cfg.svh"
module sfc_flash_host #(
  parameter int DIV     = `SFC_SCK_DIV,
  parameter int CS_HIGH = `SFC_CS_HIGH_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  sfc_spi_if.host          spi,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [23:0] addr_i,
  input  wire logic        use_addr_i,
  input  wire logic [12:0] tx_bits_i,
  input  wire logic [7:0]  data_i,
  output logic             data_take_o,
  output logic [7:0]       rx_data_o,
  output logic             done_o
);
  localparam int HALF = DIV / 2;

  if (DIV < 4 || DIV % 2 != 0 || CS_HIGH < 4 || CS_HIGH > 255) begin : g_chk
    $error("DIV must be even and at least 4, CS_HIGH within 4..255");
  end

  sfc_pkg::sfc_host_st_t st_r;
  logic [7:0]  cnt_r;
  logic        sck_r;
  logic        cs_n_r;
  logic [7:0]  sh_r;
  logic [12:0] bits_r;
  logic [12:0] total_r;
  logic [12:0] idx_r;
  logic [23:0] addr_r;
  logic        use_addr_r;
  logic        so_s1_r;
  logic        so_s2_r;
  logic [7:0]  next_byte;

  always_comb begin
    case (idx_r[1:0])
      2'd1:    next_byte = addr_r[23:16];
      2'd2:    next_byte = addr_r[15:8];
      default: next_byte = addr_r[7:0];
    endcase
    if (!use_addr_r || idx_r >= 13'(`SFC_ADDR_END)) begin
      next_byte = data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      so_s1_r <= 1'b0;
      so_s2_r <= 1'b0;
    end else begin
      so_s1_r <= spi.so_line;
      so_s2_r <= so_s1_r;
    end
  end

  // mode 0: data moves on the falling edge, device samples on the rising one
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r        <= sfc_pkg::hs_idle;
      cnt_r       <= 8'd0;
      sck_r       <= 1'b0;
      cs_n_r      <= 1'b1;
      sh_r        <= 8'h00;
      bits_r      <= 13'd0;
      total_r     <= 13'd0;
      idx_r       <= 13'd0;
      addr_r      <= 24'h000000;
      use_addr_r  <= 1'b0;
      cmd_ready_o <= 1'b0;
      data_take_o <= 1'b0;
      rx_data_o   <= 8'h00;
      done_o      <= 1'b0;
    end else begin
      data_take_o <= 1'b0;
      done_o      <= 1'b0;
      case (st_r)
        sfc_pkg::hs_idle: begin
          cmd_ready_o <= !cmd_valid_i;
          if (cmd_valid_i && cmd_ready_o) begin
            st_r        <= sfc_pkg::hs_run;
            cmd_ready_o <= 1'b0;
            cs_n_r      <= 1'b0;
            sh_r        <= opcode_i;
            addr_r      <= addr_i;
            use_addr_r  <= use_addr_i;
            total_r     <= tx_bits_i;
            bits_r      <= 13'd0;
            idx_r       <= 13'd1;
            cnt_r       <= 8'd0;
          end
        end
        sfc_pkg::hs_run: begin
          cnt_r <= cnt_r + 8'd1;
          if (cnt_r == 8'(HALF - 1)) begin
            cnt_r <= 8'd0;
            if (!sck_r) begin
              sck_r  <= 1'b1;
              bits_r <= bits_r + 13'd1;
            end else begin
              sck_r     <= 1'b0;
              rx_data_o <= {rx_data_o[6:0], so_s2_r};
              if (bits_r == total_r) begin
                st_r <= sfc_pkg::hs_tail;
              end else if (bits_r[2:0] == 3'd0) begin
                sh_r  <= next_byte;
                idx_r <= idx_r + 13'd1;
                data_take_o <= !use_addr_r || idx_r >= 13'(`SFC_ADDR_END);
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
          end
        end
        sfc_pkg::hs_tail: begin
          cnt_r <= cnt_r + 8'd1;
          if (cnt_r == 8'(HALF - 1)) begin
            cnt_r  <= 8'd0;
            cs_n_r <= 1'b1;
            st_r   <= sfc_pkg::hs_gap;
          end
        end
        sfc_pkg::hs_gap: begin
          cnt_r <= cnt_r + 8'd1;
          if (cnt_r == 8'(CS_HIGH - 1)) begin
            cnt_r  <= 8'd0;
            done_o <= 1'b1;
            st_r   <= sfc_pkg::hs_idle;
          end
        end
        default: begin
          st_r <= sfc_pkg::hs_idle;
        end
      endcase
    end
  end

  assign spi.sck  = sck_r;
  assign spi.cs_n = cs_n_r;
  assign spi.si   = sh_r[7];
endmodule

// ===== sim/sfc_flash_props.sv
module sfc_flash_props #(
  parameter int MEM_BYTES = 65536
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic busy_o,
  input wire logic wel_o,
  input wire logic erase_error_flag_o,
  input wire logic program_error_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] busy_cnt_r;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_r <= 20'h00000;
    end else begin
      busy_cnt_r <= busy_o ? busy_cnt_r + 20'h00001 : 20'h00000;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_busy_len_cap: assert property (busy_cnt_r <= 20'(MEM_BYTES + 2))
    else $error("busy held longer than a whole-array erase");
  a_busy_min_run: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy dropped too soon");
  a_start_on_deselect: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 2))
    else $error("operation started while selected");
  a_wel_clear_erase: assert property (busy_o && $past(busy_o) |-> !wel_o)
    else $error("latch still set while busy");
  a_wel_fall_idle: assert property ($fell(wel_o) |-> cs_n)
    else $error("latch cleared mid-frame");
  a_wel_set_idle: assert property ($rose(wel_o) |-> cs_n && !busy_o)
    else $error("latch set while busy or selected");
  a_err_flags_pair: assert property (erase_error_flag_o == program_error_flag_o)
    else $error("error flags differ");
  a_err_set_busy: assert property ($rose(erase_error_flag_o) |-> busy_o)
    else $error("error flag set outside an erase");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock runs while deselected");
  a_si_hold_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("data line moved while clock high");
  cover property ($rose(busy_o));
  cover property ($fell(wel_o) && !busy_o);
  cover property ($rose(erase_error_flag_o));
  cover property ($fell(busy_o));
endmodule

// ===== sim/test_spi_flash_erase_program_ctrl.sv
module test_spi_flash_erase_program_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MEMB = 65536;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic        use_addr = 1'b0;
  logic [12:0] tx_bits = 13'h0008;
  logic [7:0]  data = 8'h00;
  logic [2:0]  bp = 3'h0;
  logic        lsel = 1'b0;
  logic        blk_lock = 1'b0;
  logic        fault = 1'b0;
  logic [23:0] rd_addr = 24'h000000;
  logic        cmd_ready, data_take, done, busy, write_enable_latch, ee, pe;
  logic [7:0]  rx_data, rd_data;
  logic [7:0]  dq[$];
  logic [7:0]  ops[5] = '{8'h02, 8'h02, 8'h20, 8'h20, 8'h60};
  int          nbs[5] = '{24, 44, 24, 33, 12};
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  always #20 ref_clk = ~ref_clk;
  sfc_spi_if i_sfc_spi_if ();
  sfc_flash_host i_sfc_flash_host (.ref_clk_i(ref_clk), .nrst_i(nrst), .spi(i_sfc_spi_if.host),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .opcode_i(opcode), .addr_i(addr),
    .use_addr_i(use_addr), .tx_bits_i(tx_bits), .data_i(data), .data_take_o(data_take),
    .rx_data_o(rx_data), .done_o(done));
  sfc_flash_dev #(.MEM_BYTES(MEMB)) i_sfc_flash_dev (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .spi(i_sfc_spi_if.dev), .block_protect_field_i(bp), .lock_scheme_select_i(lsel),
    .block_lock_any_i(blk_lock), .erase_fault_i(fault), .rd_addr_i(rd_addr), .busy_o(busy),
    .wel_o(write_enable_latch), .erase_error_flag_o(ee), .program_error_flag_o(pe), .rd_data_o(rd_data));
  sfc_flash_props #(.MEM_BYTES(MEMB)) i_sfc_flash_props (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .sck(i_sfc_spi_if.sck), .cs_n(i_sfc_spi_if.cs_n), .si(i_sfc_spi_if.si), .busy_o(busy),
    .wel_o(write_enable_latch), .erase_error_flag_o(ee), .program_error_flag_o(pe));
  // next byte goes out a half cycle after the host reports a take
  always @(negedge ref_clk) begin
    if (data_take === 1'b1 && dq.size() > 0) begin
      void'(dq.pop_front());
    end
    data = (dq.size() > 0) ? dq[0] : 8'h00;
  end
  task automatic give_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 98000) begin
      failures++;
      $display("[FAIL] %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // bounded so a dead handshake still reaches the verdict
  task automatic wait_sig(input bit want_done);
    int n;
    n = 0;
    while ((want_done ? done : cmd_ready) !== 1'b1 && n < 30000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 30000) begin
      cmp(8'h00, 8'h01, "handshake hang");
    end
  endtask
  // ready must be seen before valid rises, valid held low until done
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int nb);
    @(negedge ref_clk);
    wait_sig(1'b0);
    opcode = op;
    addr = a;
    use_addr = (nb > 8);
    tx_bits = 13'(nb);
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_sig(1'b1);
  endtask
  task automatic chk_sr(input logic [7:0] e);
    xfer(8'h05, 24'h000000, 16);
    cmp(rx_data, e, "status");
  endtask
  task automatic chk_mem(input logic [23:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    rd_addr = a;
    repeat (2) @(negedge ref_clk);
    cmp(rd_data, e, "array");
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      xfer(8'h05, 24'h000000, 16);
      n++;
    end while (rx_data[0] !== 1'b0 && n < 1500);
    if (rx_data[0] !== 1'b0) begin
      cmp(rx_data, 8'h00, "busy stuck");
    end
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_sr(8'h00);
    xfer(8'h06, 24'h000000, 8);
    chk_sr(8'h02);
    xfer(8'hc7, 24'h000000, 8);
    chk_sr(8'h01);
    xfer(8'h75, 24'h000000, 8);
    chk_sr(8'h01);
    idle();
    chk_sr(8'h00);
    chk_mem(24'h000000, 8'hff);
    chk_mem(24'(MEMB - 1), 8'hff);
    $display("test chip_erase done");
    dq = '{8'ha1, 8'hb2, 8'hc3};
    xfer(8'h02, 24'h0000fe, 56);
    chk_sr(8'h00);
    chk_mem(24'h0000fe, 8'hff);
    xfer(8'h06, 24'h000000, 8);
    dq = '{8'ha1, 8'hb2, 8'hc3};
    xfer(8'h02, 24'h0000fe, 56);
    chk_sr(8'h01);
    idle();
    chk_mem(24'h0000fe, 8'ha1);
    chk_mem(24'h0000ff, 8'hb2);
    chk_mem(24'h000000, 8'hc3);
    chk_mem(24'h000001, 8'hff);
    xfer(8'h06, 24'h000000, 8);
    for (int k = 0; k < 258; k++) begin
      dq.push_back(k < 256 ? 8'(k) : 8'h3c ^ 8'(k));
    end
    xfer(8'h02, 24'h000100, 32 + 258 * 8);
    idle();
    chk_mem(24'h000100, 8'h3c);
    chk_mem(24'h000101, 8'h3d);
    chk_mem(24'h000102, 8'h02);
    chk_mem(24'h0001fe, 8'hfe);
    xfer(8'h06, 24'h000000, 8);
    dq = '{8'h77};
    xfer(8'h02, 24'h001000, 40);
    idle();
    chk_mem(24'h001000, 8'h77);
    $display("test page_program done");
    for (int i = 0; i < 5; i++) begin
      xfer(8'h06, 24'h000000, 8);
      xfer(ops[i], 24'h000abc, nbs[i]);
      chk_sr(8'h00);
    end
    chk_mem(24'h000abc, 8'hff);
    chk_mem(24'h0000fe, 8'ha1);
    chk_mem(24'h001000, 8'h77);
    $display("test aborts done");
    for (int i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      bp = (i == 0) ? 3'h1 : (i == 2) ? 3'h4 : 3'h0;
      lsel = (i == 1);
      blk_lock = (i == 1);
      xfer(8'h06, 24'h000000, 8);
      chk_sr({3'b000, bp, 2'b10});
      dq = '{8'h00};
      xfer(ops[i * 2], 24'h0000fe, (i == 0) ? 40 : (i == 1) ? 32 : 8);
      chk_sr({3'b000, bp, 2'b00});
    end
    bp = 3'h0;
    lsel = 1'b0;
    blk_lock = 1'b0;
    chk_mem(24'h0000fe, 8'ha1);
    chk_mem(24'h001000, 8'h77);
    $display("test protection done");
    xfer(8'h06, 24'h000000, 8);
    xfer(8'h20, 24'h000abc, 32);
    chk_sr(8'h01);
    idle();
    chk_mem(24'h0000fe, 8'hff);
    chk_mem(24'h000100, 8'hff);
    chk_mem(24'h001000, 8'h77);
    cmp({6'h00, ee, pe}, 8'h00, "err flags");
    @(negedge ref_clk);
    fault = 1'b1;
    xfer(8'h06, 24'h000000, 8);
    xfer(8'h20, 24'h001000, 32);
    idle();
    fault = 1'b0;
    cmp({6'h00, ee, pe}, 8'h03, "err flags");
    $display("test block_erase done");
    give_verdict();
  end
endmodule
